// file: jtag_dbg_pkg.sv
// Constants and types shared by the debug and programming access port.
package jtag_dbg_pkg;
   localparam int IR_W = 4;
   localparam int DR_W = 9;
   localparam logic [3:0] IR_DBG_READ = 4'h8;
   localparam logic [3:0] IR_DBG_ENABLE = 4'h9;
   localparam logic [3:0] IR_DBG_BREAK = 4'hA;
   localparam logic [3:0] IR_DBG_PEEK = 4'hB;
   localparam logic [3:0] IR_PROG = 4'hC;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   localparam int LEN_READ = 9;
   localparam int LEN_ENABLE = 1;
   localparam int LEN_BREAK = 4;
   localparam int LEN_PEEK = 8;
   localparam int LEN_PROG = 4;
   localparam int LEN_BYPASS = 1;
   localparam int DIRTY_BIT = 7;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [1:0] PROG_NVM = 2'h1;
   localparam logic [1:0] PROG_FUSE = 2'h2;
   localparam logic [1:0] PROG_LOCK = 2'h3;

   typedef enum {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } tap_state_e;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } tap_pins_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } cpu_req_s;
endpackage

// file: jtag_dbg_access.sv
// Test access port with debug byte channel, debug gating and programming.
`timescale 1ns/1ps
// Summary of operation
// - Test access port stays disabled unless the port fuse is programmed.
// - Port also needs the tap disable bit cleared.
// - Debug works only with debug fuse programmed and no lock bit set.
// - Any set lock bit disables debug entirely.
// - Opcodes 8, 9, A and B select debug system access.
// - CPU byte write to debug register becomes visible to debugger.
// - That CPU write sets the dirty flag at the same time.
// - CPU read returns low seven bits and dirty flag in bit 7.
// - Debug register reachable only if fuse programmed and debugger enabled.
// - Debug fuse cannot be programmed while locks set, until chip erase.
// - Programming needs only the four port signals.
// - Port programs and verifies flash, EEPROM, fuses and lock bits.
// - Lock protection for port programming matches parallel programming.
// - Break unit offers flow break, single step and break points.
// - Instruction register is four bits wide.
// - All shift registers move least significant bit first.
module jtag_dbg_access
   import jtag_dbg_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Test access port pins
   input wire tap_pins_s tap_pins,
   output logic tdo,
   output logic tdo_oe,
   // Fuses and lock bits; debug fuse and locks sampled after reset, port fuse and tap disable bit used live
   input wire logic tap_port_fuse,
   input wire logic tap_disable_bit,
   input wire logic debug_fuse_init,
   input wire logic [1:0] lock_init,
   // CPU side of the debug byte register
   input wire cpu_req_s cpu_req,
   output logic [7:0] io_rdata,
   output logic io_std_sel,
   // Status and control out
   output logic dbg_active,
   output logic [3:0] break_ctrl,
   output logic debug_enable_fuse,
   output logic [1:0] lock_bits,
   output logic nvm_req,
   output logic [1:0] nvm_data
);
   // ************************************************************
   // Pin synchronisers and clock edge detection
   // ************************************************************
   // The test clock is slow next to sys_clk, so edges are found by sampling.
   tap_pins_s meta_r, sync_r;
   logic tck_d_r;
   logic rise, fall;
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         meta_r <= '0;
         sync_r <= '0;
         tck_d_r <= 1'b0;
      end else begin
         meta_r <= tap_pins;
         sync_r <= meta_r;
         tck_d_r <= sync_r.tck;
      end
   end
   assign rise = sync_r.tck & ~tck_d_r;
   assign fall = ~sync_r.tck & tck_d_r;

   // ************************************************************
   // Enables
   // ************************************************************
   logic tap_en, dbg_en;
   logic loaded_r, dfuse_r, dfuse_nxt;
   logic [1:0] lock_r, lock_nxt;
   assign tap_en = tap_port_fuse & ~tap_disable_bit;
   assign dbg_en = tap_en & dfuse_r & (lock_r == 2'b00);

   // ************************************************************
   // Controller state machine
   // ************************************************************
   tap_state_e st_r, st_nxt;
   always_comb begin
      st_nxt = st_r;
      if (!tap_en) begin
         st_nxt = TLR;
      end else if (rise) begin
         case (st_r)
            TLR: st_nxt = sync_r.tms ? TLR : RTI;
            RTI: st_nxt = sync_r.tms ? SEL_DR : RTI;
            SEL_DR: st_nxt = sync_r.tms ? SEL_IR : CAP_DR;
            CAP_DR: st_nxt = sync_r.tms ? EX1_DR : SH_DR;
            SH_DR: st_nxt = sync_r.tms ? EX1_DR : SH_DR;
            EX1_DR: st_nxt = sync_r.tms ? UPD_DR : PAU_DR;
            PAU_DR: st_nxt = sync_r.tms ? EX2_DR : PAU_DR;
            EX2_DR: st_nxt = sync_r.tms ? UPD_DR : SH_DR;
            UPD_DR: st_nxt = sync_r.tms ? SEL_DR : RTI;
            SEL_IR: st_nxt = sync_r.tms ? TLR : CAP_IR;
            CAP_IR: st_nxt = sync_r.tms ? EX1_IR : SH_IR;
            SH_IR: st_nxt = sync_r.tms ? EX1_IR : SH_IR;
            EX1_IR: st_nxt = sync_r.tms ? UPD_IR : PAU_IR;
            PAU_IR: st_nxt = sync_r.tms ? EX2_IR : PAU_IR;
            EX2_IR: st_nxt = sync_r.tms ? UPD_IR : SH_IR;
            UPD_IR: st_nxt = sync_r.tms ? SEL_DR : RTI;
            default: st_nxt = TLR;
         endcase
      end
   end

   // ************************************************************
   // Shift paths, instruction and data registers
   // ************************************************************
   logic [IR_W-1:0] ir_r, ir_nxt, irs_r, irs_nxt;
   logic [DR_W-1:0] dr_r, dr_nxt;
   logic [7:0] byte_r, byte_nxt;
   logic dirty_r, dirty_nxt, acc_r, acc_nxt;
   logic [3:0] brk_r, brk_nxt;
   logic nreq_r, nreq_nxt;
   logic [1:0] ndata_r, ndata_nxt;
   logic tdo_r, tdo_nxt, oe_r, oe_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic std_r, std_nxt, act_r, act_nxt;
   logic cpu_sel, is_dbg, dbg_clr;
   int len;

   // Private opcodes answer only while debug is allowed; else bypass.
   assign is_dbg = dbg_en && ir_r[3:2] == 2'b10;
   assign cpu_sel = dbg_en & acc_r;
   assign dbg_clr = rise && st_r == UPD_DR && is_dbg && ir_r == IR_DBG_READ;

   always_comb begin
      case (ir_r)
         IR_DBG_READ: len = is_dbg ? LEN_READ : LEN_BYPASS;
         IR_DBG_ENABLE: len = is_dbg ? LEN_ENABLE : LEN_BYPASS;
         IR_DBG_BREAK: len = is_dbg ? LEN_BREAK : LEN_BYPASS;
         IR_DBG_PEEK: len = is_dbg ? LEN_PEEK : LEN_BYPASS;
         IR_PROG: len = LEN_PROG;
         default: len = LEN_BYPASS;
      endcase
   end

   always_comb begin
      ir_nxt = ir_r;
      irs_nxt = irs_r;
      dr_nxt = dr_r;
      acc_nxt = acc_r;
      brk_nxt = brk_r;
      dfuse_nxt = dfuse_r;
      lock_nxt = lock_r;
      nreq_nxt = 1'b0;
      ndata_nxt = ndata_r;
      tdo_nxt = tdo_r;
      oe_nxt = oe_r;
      if (st_r == TLR) begin
         ir_nxt = IR_BYPASS;
         acc_nxt = 1'b0;
         brk_nxt = 4'h0;
      end
      if (!dbg_en) begin
         acc_nxt = 1'b0;
         brk_nxt = 4'h0;
      end
      if (rise) begin
         case (st_r)
            CAP_IR: irs_nxt = IR_CAPTURE;
            SH_IR: irs_nxt = {sync_r.tdi, irs_r[IR_W-1:1]};
            UPD_IR: ir_nxt = irs_r;
            CAP_DR: begin
               dr_nxt = '0;
               if (is_dbg && (ir_r == IR_DBG_READ || ir_r == IR_DBG_PEEK))
                  dr_nxt = {dirty_r, byte_r};
               else if (is_dbg && ir_r == IR_DBG_BREAK)
                  dr_nxt = {5'h00, brk_r};
               else if (ir_r == IR_PROG)
                  dr_nxt = {5'h00, dfuse_r, 1'b0, lock_r};
            end
            SH_DR: begin
               for (int i = 0; i < DR_W; i++)
                  dr_nxt[i] = (i == len - 1) ? sync_r.tdi :
                     (i < DR_W - 1 ? dr_r[i + 1] : 1'b0);
            end
            UPD_DR: begin
               if (is_dbg && ir_r == IR_DBG_ENABLE)
                  acc_nxt = dr_r[0];
               if (is_dbg && ir_r == IR_DBG_BREAK)
                  brk_nxt = dr_r[3:0];
               if (ir_r == IR_PROG) begin
                  case (dr_r[3:2])
                     PROG_NVM: begin
                        nreq_nxt = 1'b1;
                        ndata_nxt = dr_r[1:0];
                     end
                     PROG_FUSE: begin
                        // Locks set: fuse may be cleared, never programmed.
                        if (lock_r == 2'b00 || !dr_r[0])
                           dfuse_nxt = dr_r[0];
                     end
                     PROG_LOCK: begin
                        // Zero data is chip erase, the only way to drop locks.
                        if (dr_r[1:0] == 2'b00)
                           lock_nxt = 2'b00;
                        else
                           lock_nxt = lock_r | dr_r[1:0];
                     end
                     default: ;
                  endcase
               end
            end
            default: ;
         endcase
      end
      if (fall) begin
         oe_nxt = (st_r == SH_DR) || (st_r == SH_IR);
         tdo_nxt = (st_r == SH_IR) ? irs_r[0] : dr_r[0];
      end
      if (!tap_en) begin
         oe_nxt = 1'b0;
      end
   end

   // ************************************************************
   // CPU side of the debug byte register
   // ************************************************************
   always_comb begin
      byte_nxt = byte_r;
      dirty_nxt = dirty_r;
      rdata_nxt = rdata_r;
      std_nxt = ~cpu_sel;
      act_nxt = dbg_en;
      if (dbg_clr)
         dirty_nxt = 1'b0;
      if (cpu_sel && cpu_req.wr) begin
         byte_nxt = cpu_req.wdata;
         dirty_nxt = 1'b1;
      end
      if (cpu_sel && cpu_req.rd)
         rdata_nxt = {dirty_r, byte_r[DIRTY_BIT-1:0]};
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         st_r <= TLR;
         ir_r <= IR_BYPASS;
         irs_r <= '0;
         dr_r <= '0;
         byte_r <= BYTE_RESET;
         dirty_r <= 1'b0;
         acc_r <= 1'b0;
         brk_r <= 4'h0;
         nreq_r <= 1'b0;
         ndata_r <= 2'b00;
         tdo_r <= 1'b0;
         oe_r <= 1'b0;
         rdata_r <= 8'h00;
         std_r <= 1'b1;
         act_r <= 1'b0;
         loaded_r <= 1'b0;
         dfuse_r <= 1'b0;
         lock_r <= 2'b00;
      end else begin
         st_r <= st_nxt;
         ir_r <= ir_nxt;
         irs_r <= irs_nxt;
         dr_r <= dr_nxt;
         byte_r <= byte_nxt;
         dirty_r <= dirty_nxt;
         acc_r <= acc_nxt;
         brk_r <= brk_nxt;
         nreq_r <= nreq_nxt;
         ndata_r <= ndata_nxt;
         tdo_r <= tdo_nxt;
         oe_r <= oe_nxt;
         rdata_r <= rdata_nxt;
         std_r <= std_nxt;
         act_r <= act_nxt;
         loaded_r <= 1'b1;
         // Nonvolatile state is caught once, on the first edge after reset.
         dfuse_r <= loaded_r ? dfuse_nxt : debug_fuse_init;
         lock_r <= loaded_r ? lock_nxt : lock_init;
      end
   end

   assign tdo = tdo_r;
   assign tdo_oe = oe_r;
   assign io_rdata = rdata_r;
   assign io_std_sel = std_r;
   assign dbg_active = act_r;
   assign break_ctrl = brk_r;
   assign debug_enable_fuse = dfuse_r;
   assign lock_bits = lock_r;
   assign nvm_req = nreq_r;
   assign nvm_data = ndata_r;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   port_off_a: assert property (!tap_en |=> st_r == TLR && !tdo_oe)
      else $error("port active while disabled");
   jtd_gate_a: assert property (tap_disable_bit |=> !tdo_oe)
      else $error("tdo driven with tap disable bit set");
   dbg_gate_a: assert property (dbg_active |-> $past(dfuse_r))
      else $error("debug active without fuse");
   lock_kill_a: assert property (lock_r != 2'b00 |=> !dbg_active)
      else $error("debug active with lock set");
   op_len_a: assert property (is_dbg && ir_r == IR_DBG_READ |-> len == LEN_READ)
      else $error("read opcode has wrong length");
   wr_dirty_a: assert property (cpu_sel && cpu_req.wr |=>
      dirty_r && byte_r == $past(cpu_req.wdata))
      else $error("cpu write lost");
   rd_map_a: assert property (cpu_sel && cpu_req.rd |=>
      io_rdata == {$past(dirty_r), $past(byte_r[6:0])})
      else $error("read layout wrong");
   clr_flag_a: assert property (dbg_clr && !(cpu_sel && cpu_req.wr) |=>
      !dirty_r)
      else $error("dirty not cleared");
   sel_route_a: assert property (!cpu_sel |=> io_std_sel)
      else $error("debug register reached without enable");
   fuse_lock_a: assert property (lock_r != 2'b00 && loaded_r && !dfuse_r
      |=> !dfuse_r)
      else $error("fuse programmed while locked");
   ir_upd_a: assert property (rise && st_r == UPD_IR && tap_en |=>
      ir_r == $past(irs_r))
      else $error("instruction not updated");

   rd_cov_c: cover property (dbg_clr);
   wr_cov_c: cover property (cpu_sel && cpu_req.wr && dirty_r);
   prog_cov_c: cover property (nreq_r);
endmodule // jtag_dbg_access

// file: jtag_host.sv
// Debugger model that drives the test access port pins.
`timescale 1ns/1ps
module jtag_host
   import jtag_dbg_pkg::*;
(
   // System clock
   input wire logic sys_clk,
   // Port pins
   output tap_pins_s pins,
   input wire logic tdo,
   input wire logic tdo_oe
);
   int gap = 0;

   initial pins = '0;

   // One test clock of eight system clocks; tdo is read while tck is high.
   task automatic tick(input logic ms, input logic di, output logic dout);
      @(posedge sys_clk);
      pins.tms <= ms;
      pins.tdi <= di;
      pins.tck <= 1'b0;
      repeat (4) @(posedge sys_clk);
      pins.tck <= 1'b1;
      @(negedge sys_clk);
      // A released pin floats; reading the inverse exposes a stale sample.
      dout = tdo_oe ? tdo : ~tdo;
      repeat (3) @(posedge sys_clk);
   endtask

   // Starts from reset or idle, returns to idle with tck parked low.
   // Outside the shift bits tdi toggles, so stale data never looks valid.
   task automatic scan(input logic ir, input logic [8:0] din, input int len,
      output logic [8:0] dout);
      logic b;
      dout = '0;
      repeat (gap + 1) tick(1'b0, ~pins.tdi, b);
      tick(1'b1, ~pins.tdi, b);
      if (ir) tick(1'b1, ~pins.tdi, b);
      tick(1'b0, ~pins.tdi, b);
      tick(1'b0, ~pins.tdi, b);
      for (int i = 0; i < len; i++) begin
         tick(i == len - 1, din[i], b);
         dout[i] = b;
      end
      tick(1'b1, ~pins.tdi, b);
      tick(1'b0, ~pins.tdi, b);
      @(posedge sys_clk);
      pins.tck <= 1'b0;
      @(negedge sys_clk);
   endtask
endmodule // jtag_host

// file: tb_top.sv
// Self-checking bench for the debug and programming access port.
`timescale 1ns/1ps
module tb_top;
   import jtag_dbg_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   tap_pins_s tap_pins;
   cpu_req_s cpu_req = '0;
   logic tap_port_fuse = 1'b0;
   logic tap_disable_bit = 1'b0;
   logic debug_fuse_init = 1'b1;
   logic [1:0] lock_init = 2'h0;
   logic tdo, tdo_oe, io_std_sel, dbg_active, nvm_req, debug_enable_fuse;
   logic [7:0] io_rdata;
   logic [3:0] break_ctrl;
   logic [1:0] lock_bits, nvm_data;
   logic rd_p = 1'b0;
   logic [15:0] exp_q[$];
   int mismatches = 0;
   int checks = 0;
   int oe_cnt = 0;
   integer seed = 32'he436;
   logic [8:0] cap;
   logic [7:0] b1, b2;
   logic [3:0] v;

   always #12.5 sys_clk = ~sys_clk;

   jtag_dbg_access u_dut (.sys_clk(sys_clk), .resetn(resetn),
      .tap_pins(tap_pins), .tdo(tdo), .tdo_oe(tdo_oe),
      .tap_port_fuse(tap_port_fuse), .tap_disable_bit(tap_disable_bit),
      .debug_fuse_init(debug_fuse_init), .lock_init(lock_init),
      .cpu_req(cpu_req), .io_rdata(io_rdata), .io_std_sel(io_std_sel),
      .dbg_active(dbg_active), .break_ctrl(break_ctrl),
      .debug_enable_fuse(debug_enable_fuse), .lock_bits(lock_bits),
      .nvm_req(nvm_req), .nvm_data(nvm_data));
   jtag_host u_host (.sys_clk(sys_clk), .pins(tap_pins), .tdo(tdo),
      .tdo_oe(tdo_oe));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic cpu(input logic w, input logic [7:0] d);
      @(posedge sys_clk);
      cpu_req <= '{wr: w, rd: ~w, wdata: d};
   endtask

   task automatic cpu_idle;
      @(posedge sys_clk);
      cpu_req <= '0;
   endtask

   // Each shifted bit keeps tdo driven for one test clock of eight cycles.
   task automatic dr(input logic [3:0] op, input logic [8:0] d, input int n);
      int base;
      base = oe_cnt;
      u_host.scan(1'b1, {5'h00, op}, 4, cap);
      chk(16'(cap), 16'h0001);
      chk(16'(oe_cnt - base), 16'h0020);
      base = oe_cnt;
      u_host.scan(1'b0, d, n, cap);
      chk(16'(oe_cnt - base), 16'(8 * n));
   endtask

   // ****************************************
   // Result watcher: oldest note against each read or request.
   // ****************************************
   always @(posedge sys_clk) rd_p <= cpu_req.rd;

   always @(negedge sys_clk) if (tdo_oe) oe_cnt++;

   always @(negedge sys_clk) begin
      if (rd_p || nvm_req) begin
         if (exp_q.size() == 0)
            chk(16'hdead, 16'h0000);
         else if (rd_p)
            chk({8'h00, io_rdata}, exp_q.pop_front());
         else
            chk({14'h0000, nvm_data}, exp_q.pop_front());
      end
   end

   initial begin
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (3) @(negedge sys_clk);
      chk(16'({io_std_sel, dbg_active, io_rdata}), 16'h0200);
      u_host.scan(1'b1, 9'h009, 4, cap);
      chk(16'(cap), 16'h000f);
      @(posedge sys_clk);
      tap_port_fuse <= 1'b1;
      tap_disable_bit <= 1'b1;
      u_host.scan(1'b1, 9'h009, 4, cap);
      chk(16'(cap), 16'h000f);
      @(posedge sys_clk);
      tap_disable_bit <= 1'b0;
      repeat (3) @(negedge sys_clk);
      chk(16'(dbg_active), 16'h0001);
      b1 = 8'($random(seed));
      b2 = 8'($random(seed));
      cpu(1'b1, b1);
      cpu_idle();
      dr(IR_DBG_ENABLE, 9'h001, LEN_ENABLE);
      chk(16'(io_std_sel), 16'h0000);
      exp_q.push_back(16'h0000);
      exp_q.push_back({8'h00, 1'b1, b2[6:0]});
      cpu(1'b0, 8'h00);
      cpu(1'b1, b1);
      cpu(1'b1, b2);
      cpu(1'b0, 8'h00);
      cpu_idle();
      u_host.gap = 3;
      dr(IR_DBG_PEEK, 9'h000, LEN_PEEK);
      chk(16'(cap), 16'({1'b0, b2}));
      dr(IR_DBG_READ, 9'h000, LEN_READ);
      chk(16'(cap), 16'({1'b1, b2}));
      exp_q.push_back({8'h00, 1'b0, b2[6:0]});
      cpu(1'b0, 8'h00);
      cpu_idle();
      v = 4'($random(seed));
      dr(IR_DBG_BREAK, {5'h00, v}, LEN_BREAK);
      chk(16'(break_ctrl), 16'(v));
      u_host.gap = 0;
      dr(IR_PROG, 9'h00d, LEN_PROG);
      chk(16'({lock_bits, dbg_active}), 16'h0002);
      dr(IR_DBG_READ, 9'h0a5, LEN_READ);
      chk(16'({io_std_sel, cap}), 16'h034a);
      dr(IR_PROG, 9'h008, LEN_PROG);
      u_host.scan(1'b0, 9'h009, LEN_PROG, cap);
      chk(16'(debug_enable_fuse), 16'h0000);
      u_host.scan(1'b0, 9'h00c, LEN_PROG, cap);
      chk(16'({lock_bits, debug_enable_fuse, dbg_active}), 16'h0000);
      u_host.scan(1'b0, 9'h009, LEN_PROG, cap);
      chk(16'({lock_bits, debug_enable_fuse, dbg_active}), 16'h0003);
      exp_q.push_back(16'h0002);
      u_host.scan(1'b0, 9'h006, LEN_PROG, cap);
      repeat (4) @(negedge sys_clk);
      chk(16'(exp_q.size()), 16'h0000);
      report_and_stop();
   end

   // A hang ends the run as a failure.
   initial begin
      repeat (40000) @(posedge sys_clk);
      mismatches++;
      report_and_stop();
   end
endmodule // tb_top
